// [hdl/fsi_crc_sync_count.sv]
`timescale 1ns/1ps
module fsi_crc_sync_count
(
	input  wire logic                          core_clk,
	input  wire logic                          nrst,
	input  wire logic                          crc4_enable,
	input  wire logic                          crc_mf_synced,
	input  wire logic                          crc_mf_timeout,
	output logic      [fsi_pkg::CRC_CNT_W-1:0] count
);
	import fsi_pkg::*;

	fsi_cnt_state_t st_r;
	fsi_cnt_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (!crc4_enable || crc_mf_synced)
			st_nxt.count = RST_COUNT;
		else if (crc_mf_timeout)
			st_nxt.count = st_r.count + 6'h01;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			st_r <= '{count: RST_COUNT};
		else
			st_r <= st_nxt;
	end

	assign count = st_r.count;

	chk_count_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		(!crc4_enable || crc_mf_synced) |=> (count == RST_COUNT))
		else $error("sync counter not cleared");

	chk_count_step: assert property (@(posedge core_clk) disable iff (!nrst)
		(crc4_enable && !crc_mf_synced && crc_mf_timeout)
		|=> (count == $past(count) + 6'h01))
		else $error("sync counter did not step or roll over");

endmodule : fsi_crc_sync_count

// [hdl/fsi_pkg.sv]
// Summary of operation
// - Status and information bits latch when set
// - Read clears bit; persisting alarms stay set
// - Write refreshes read-back only at one positions
// - Synchronizer status is live, read-only, unlatched
// - Status bits interrupt only when mask enables
// - Mask bit 0 masks, 1 enables
// - Alarm change of state in either direction interrupts
// - Reading alarm bit releases its interrupt
// - Event interrupts; reading its bit releases it
// - Periodic events interrupt repeatedly while present
// - Once-type events interrupt on first detection only
// - Pattern detect rearms after pattern stops
// - Unused addresses read as zero
// - Summary bit 2n status one, +1 two
// - Gain monitor level in bits 7 and 6
// - Jitter limit trip flag at bit 5
// - Elastic store full bit 4, empty bit 3
// - CRC resync criteria flag at bit 2
// - Frame alignment resync criteria flag at bit 1
// - Signaling multiframe resync flag at bit 0
// - Sync counter bits 5..2,0 at 7..3
// - Search active flags at bits 2,1,0
// - Counter counts timeouts, clears on sync, rolls over
package fsi_pkg;

	localparam int          NUM_PORTS      = 4;
	localparam int          CRC_CNT_W      = 6;
	localparam logic [7:0]  ADDR_RX_INFO   = 8'h08;
	localparam logic [7:0]  ADDR_SYNC_STAT = 8'h09;
	localparam logic [7:0]  ADDR_STAT_ONE  = 8'h0a;
	localparam logic [7:0]  ADDR_STAT_TWO  = 8'h0b;
	localparam logic [7:0]  ADDR_SUM_LO    = 8'h0c;
	localparam logic [7:0]  ADDR_SUM_HI    = 8'h0e;
	localparam logic [7:0]  ADDR_MASK_ONE  = 8'h18;
	localparam logic [7:0]  ADDR_MASK_TWO  = 8'h19;
	// Interrupt behaviour of each status bit
	localparam logic [7:0]  ONE_ALARM      = 8'h0f;
	localparam logic [7:0]  ONE_ONCE       = 8'he0;
	localparam logic [7:0]  ONE_REPEAT     = 8'h10;
	localparam logic [7:0]  TWO_ONCE       = 8'h05;
	localparam logic [7:0]  TWO_REPEAT     = 8'hfa;
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [CRC_CNT_W-1:0] RST_COUNT = 6'h00;

	typedef logic [NUM_PORTS-1:0][7:0] fsi_bytes_t;

	typedef struct packed {
		fsi_bytes_t lat1;
		fsi_bytes_t lat2;
		fsi_bytes_t latr;
		fsi_bytes_t rb1;
		fsi_bytes_t rb2;
		fsi_bytes_t rbr;
		fsi_bytes_t pm1;
		fsi_bytes_t pm2;
		fsi_bytes_t pmr;
		fsi_bytes_t pend1;
		fsi_bytes_t pend2;
		fsi_bytes_t irq_mask_one;
		fsi_bytes_t irq_mask_two;
		fsi_bytes_t prev1;
		fsi_bytes_t prev2;
		logic [7:0] rdata;
		logic       irq_n;
	} fsi_state_t;

	typedef struct packed {
		logic [CRC_CNT_W-1:0] count;
	} fsi_cnt_state_t;

endpackage : fsi_pkg

// [hdl/fsi_top.sv]
`timescale 1ns/1ps
module fsi_top
(
	input  wire logic                                      core_clk,
	input  wire logic                                      nrst,
	input  wire logic [1:0]                                host_port_sel,
	input  wire logic [7:0]                                host_addr,
	input  wire logic                                      host_wr,
	input  wire logic                                      host_rd,
	input  wire logic [7:0]                                host_wdata,
	output logic      [7:0]                                host_rdata,
	output logic                                           irq_n,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0][7:0]        event_status_one_in,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0][7:0]        event_status_two_in,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0][1:0]        gain_monitor_in,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             jitter_fifo_limit_trip,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             elastic_store_full,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             elastic_store_empty,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             crc_resync_criteria,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             frame_align_resync_criteria,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             signaling_mf_resync_criteria,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             frame_align_search_active,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             signaling_mf_search_active,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             crc_mf_search_active,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             crc4_enable,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             crc_mf_synced,
	input  wire logic [fsi_pkg::NUM_PORTS-1:0]             crc_mf_timeout
);
	import fsi_pkg::*;

	fsi_state_t                          st_r;
	fsi_state_t                          st_nxt;
	logic [NUM_PORTS-1:0][CRC_CNT_W-1:0] sync_count;
	fsi_bytes_t                          rx_info_in;
	fsi_bytes_t                          sync_stat;
	logic [7:0]                          summary;

	// Latch: clear reported positions, but a new set wins
	function automatic logic [7:0] latch_upd(input logic [7:0] lat,
		input logic [7:0] clr, input logic [7:0] set);
		latch_upd = (lat & ~clr) | set;
	endfunction : latch_upd

	// Read-back refresh: only positions written as one take fresh status
	function automatic logic [7:0] refresh(input logic [7:0] rb,
		input logic [7:0] lat, input logic [7:0] wmask);
		refresh = (lat & wmask) | (rb & ~wmask);
	endfunction : refresh

	// Interrupt sources: alarms on any change, once-type on rising edge, repeat on level
	function automatic logic [7:0] irq_set(input logic [7:0] now, input logic [7:0] prev,
		input logic [7:0] alarm, input logic [7:0] once, input logic [7:0] rep);
		irq_set = (alarm & (now ^ prev)) | (once & now & ~prev) | (rep & now);
	endfunction : irq_set

	// Summary byte: port n status one at bit 2n, status two at 2n+1
	function automatic logic [7:0] sum_of(input fsi_bytes_t p1, input fsi_bytes_t p2,
		input fsi_bytes_t m1, input fsi_bytes_t m2);
		logic [7:0] s;
		s = RST_BYTE;
		for (int n = 0; n < NUM_PORTS; n++)
		begin
			s[2*n]   = |(p1[n] & m1[n]);
			s[2*n+1] = |(p2[n] & m2[n]);
		end
		sum_of = s;
	endfunction : sum_of

	for (genvar g = 0; g < NUM_PORTS; g++)
	begin : g_port
		fsi_crc_sync_count u_sync_count
		(
			.core_clk       (core_clk),
			.nrst           (nrst),
			.crc4_enable    (crc4_enable[g]),
			.crc_mf_synced  (crc_mf_synced[g]),
			.crc_mf_timeout (crc_mf_timeout[g]),
			.count          (sync_count[g])
		);

		assign rx_info_in[g] = {gain_monitor_in[g],
			jitter_fifo_limit_trip[g],
			elastic_store_full[g], elastic_store_empty[g],
			crc_resync_criteria[g],
			frame_align_resync_criteria[g],
			signaling_mf_resync_criteria[g]};

		// Counter bit 1 is not visible
		assign sync_stat[g] = {sync_count[g][5:2], sync_count[g][0],
			frame_align_search_active[g],
			signaling_mf_search_active[g], crc_mf_search_active[g]};
	end

	assign summary = sum_of(st_r.pend1, st_r.pend2, st_r.irq_mask_one, st_r.irq_mask_two);

	always_comb
	begin
		logic [7:0] clr1;
		logic [7:0] clr2;
		logic [7:0] clrr;
		clr1 = RST_BYTE;
		clr2 = RST_BYTE;
		clrr = RST_BYTE;
		st_nxt = st_r;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			clr1 = RST_BYTE;
			clr2 = RST_BYTE;
			clrr = RST_BYTE;
			if (host_rd && (host_port_sel == p[1:0]))
			begin
				// A read clears whatever the last mask write exposed
				if (host_addr == ADDR_STAT_ONE)
					clr1 = st_r.pm1[p];
				else if (host_addr == ADDR_STAT_TWO)
					clr2 = st_r.pm2[p];
				else if (host_addr == ADDR_RX_INFO)
					clrr = st_r.pmr[p];
			end
			// Persisting inputs keep their latch set, as a set in the clearing cycle wins
			st_nxt.lat1[p] = latch_upd(st_r.lat1[p], clr1, event_status_one_in[p]);
			st_nxt.lat2[p] = latch_upd(st_r.lat2[p], clr2, event_status_two_in[p]);
			st_nxt.latr[p] = latch_upd(st_r.latr[p], clrr, rx_info_in[p]);
			st_nxt.pm1[p] = st_r.pm1[p] & ~clr1;
			st_nxt.pm2[p] = st_r.pm2[p] & ~clr2;
			st_nxt.pmr[p] = st_r.pmr[p] & ~clrr;
			st_nxt.pend1[p] = latch_upd(st_r.pend1[p], clr1,
				irq_set(event_status_one_in[p], st_r.prev1[p],
					ONE_ALARM, ONE_ONCE, ONE_REPEAT));
			st_nxt.pend2[p] = latch_upd(st_r.pend2[p], clr2,
				irq_set(event_status_two_in[p], st_r.prev2[p],
					RST_BYTE, TWO_ONCE, TWO_REPEAT));
			st_nxt.prev1[p] = event_status_one_in[p];
			st_nxt.prev2[p] = event_status_two_in[p];
			if (host_wr && (host_port_sel == p[1:0]))
			begin
				if (host_addr == ADDR_STAT_ONE)
				begin
					st_nxt.rb1[p] = refresh(st_r.rb1[p], st_r.lat1[p], host_wdata);
					st_nxt.pm1[p] = host_wdata;
				end
				else if (host_addr == ADDR_STAT_TWO)
				begin
					st_nxt.rb2[p] = refresh(st_r.rb2[p], st_r.lat2[p], host_wdata);
					st_nxt.pm2[p] = host_wdata;
				end
				else if (host_addr == ADDR_RX_INFO)
				begin
					st_nxt.rbr[p] = refresh(st_r.rbr[p], st_r.latr[p], host_wdata);
					st_nxt.pmr[p] = host_wdata;
				end
				else if (host_addr == ADDR_MASK_ONE)
					st_nxt.irq_mask_one[p] = host_wdata;
				else if (host_addr == ADDR_MASK_TWO)
					st_nxt.irq_mask_two[p] = host_wdata;
			end
		end
		if (host_rd)
		begin
			if (host_addr == ADDR_STAT_ONE)
				st_nxt.rdata = st_r.rb1[host_port_sel];
			else if (host_addr == ADDR_STAT_TWO)
				st_nxt.rdata = st_r.rb2[host_port_sel];
			else if (host_addr == ADDR_RX_INFO)
				st_nxt.rdata = st_r.rbr[host_port_sel];
			else if (host_addr == ADDR_SYNC_STAT)
				st_nxt.rdata = sync_stat[host_port_sel];
			else if ((host_addr >= ADDR_SUM_LO) && (host_addr <= ADDR_SUM_HI))
				st_nxt.rdata = summary;
			else if (host_addr == ADDR_MASK_ONE)
				st_nxt.rdata = st_r.irq_mask_one[host_port_sel];
			else if (host_addr == ADDR_MASK_TWO)
				st_nxt.rdata = st_r.irq_mask_two[host_port_sel];
			else
				st_nxt.rdata = RST_BYTE;
		end
		// Shared pin low while any enabled source is pending in any port
		st_nxt.irq_n = ~|sum_of(st_nxt.pend1, st_nxt.pend2,
			st_nxt.irq_mask_one, st_nxt.irq_mask_two);
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			st_r       <= '0;
			st_r.irq_n <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign host_rdata = st_r.rdata;
	assign irq_n      = st_r.irq_n;

	chk_irq_summary: assert property (@(posedge core_clk) disable iff (!nrst)
		irq_n == ~|summary)
		else $error("interrupt pin disagrees with pending sources");

	chk_mask_gates: assert property (@(posedge core_clk) disable iff (!nrst)
		(st_r.irq_mask_one[0] == RST_BYTE) |-> !summary[0])
		else $error("masked source reached summary");

	chk_alarm_change: assert property (@(posedge core_clk) disable iff (!nrst)
		(event_status_one_in[0][0] != st_r.prev1[0][0]) |=> st_r.pend1[0][0])
		else $error("alarm change did not raise interrupt");

	chk_alarm_stays: assert property (@(posedge core_clk) disable iff (!nrst)
		event_status_one_in[0][0] |=> st_r.lat1[0][0])
		else $error("persisting alarm bit not held");

	chk_repeat_evt: assert property (@(posedge core_clk) disable iff (!nrst)
		event_status_two_in[3][4] |=> st_r.pend2[3][4])
		else $error("repeating event did not raise interrupt");

	chk_once_evt: assert property (@(posedge core_clk) disable iff (!nrst)
		(st_r.prev2[1][0] && event_status_two_in[1][0] && !st_r.pend2[1][0])
		|=> !st_r.pend2[1][0])
		else $error("once-type event fired again");

	chk_read_release: assert property (@(posedge core_clk) disable iff (!nrst)
		(host_rd && host_port_sel == 2'h1 && host_addr == ADDR_STAT_TWO
		&& st_r.pm2[1][5] && !event_status_two_in[1][5]) |=> !st_r.pend2[1][5])
		else $error("read did not release event interrupt");

	chk_alarm_release: assert property (@(posedge core_clk) disable iff (!nrst)
		(host_rd && host_port_sel == 2'h0 && host_addr == ADDR_STAT_ONE && st_r.pm1[0][0]
		&& (event_status_one_in[0][0] == st_r.prev1[0][0])) |=> !st_r.pend1[0][0])
		else $error("read did not release alarm interrupt");

	chk_write_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		(host_wr && host_port_sel == 2'h0 && host_addr == ADDR_STAT_ONE && !host_wdata[0])
		|=> (st_r.rb1[0][0] == $past(st_r.rb1[0][0])))
		else $error("zero mask position changed read-back");

	chk_sync_live: assert property (@(posedge core_clk) disable iff (!nrst)
		(host_rd && host_addr == ADDR_SYNC_STAT)
		|=> (host_rdata == $past(sync_stat[host_port_sel])))
		else $error("synchronizer status not returned live");

	chk_summary_rd: assert property (@(posedge core_clk) disable iff (!nrst)
		(host_rd && host_addr == ADDR_SUM_LO) ##1 1'b1 |-> (host_rdata == $past(summary)))
		else $error("summary byte not returned");

endmodule : fsi_top

// [sim/fsi_host_model.sv]
`timescale 1ns/1ps
module fsi_host_model
(
	input  wire logic       core_clk,
	input  wire logic [7:0] host_rdata,
	output logic      [1:0] host_port_sel,
	output logic      [7:0] host_addr,
	output logic            host_wr,
	output logic            host_rd,
	output logic      [7:0] host_wdata
);
	initial
	begin
		{host_port_sel, host_addr, host_wr, host_rd, host_wdata} = '0;
	end

	task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		host_port_sel <= p;
		host_addr     <= a;
		host_wdata    <= d;
		host_wr       <= 1'b1;
		@(posedge core_clk);
		host_wr       <= 1'b0;
		// Released data lines must not keep showing the last byte
		host_wdata    <= ~d;
	endtask : wr

	task automatic rd(input logic [1:0] p, input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		host_port_sel <= p;
		host_addr     <= a;
		host_rd       <= 1'b1;
		@(posedge core_clk);
		host_rd       <= 1'b0;
		// Take the answer once it has settled, then finish on a rising edge
		@(negedge core_clk);
		d = host_rdata;
		@(posedge core_clk);
	endtask : rd

	// Mask write, read, then write back the read value limited to the mask
	task automatic poll(input logic [1:0] p, input logic [7:0] a, input logic [7:0] m,
		output logic [7:0] d);
		wr(p, a, m);
		rd(p, a, d);
		wr(p, a, d & m);
	endtask : poll
endmodule : fsi_host_model

// [sim/tb_fsi_top.sv]
`timescale 1ns/1ps
module tb_fsi_top;
	import fsi_pkg::*;
	logic            core_clk;
	logic            nrst;
	logic [1:0]      host_port_sel;
	logic [7:0]      host_addr, host_wdata, host_rdata, v;
	logic            host_wr, host_rd, irq_n;
	logic            irq_smp;
	fsi_bytes_t      ev1, ev2;
	logic [3:0][1:0] gain_monitor_in;
	logic [3:0]      jitter_fifo_limit_trip, elastic_store_full, elastic_store_empty;
	logic [3:0]      crc_resync_criteria, frame_align_resync_criteria;
	logic [3:0]      signaling_mf_resync_criteria, frame_align_search_active;
	logic [3:0]      signaling_mf_search_active, crc_mf_search_active;
	logic [3:0]      crc4_enable, crc_mf_synced, crc_mf_timeout;
	int              error_cnt, n_compared;

	fsi_top uut
	(
		.core_clk, .nrst, .host_port_sel, .host_addr, .host_wr, .host_rd, .host_wdata,
		.host_rdata, .irq_n, .event_status_one_in(ev1), .event_status_two_in(ev2),
		.gain_monitor_in, .jitter_fifo_limit_trip, .elastic_store_full,
		.elastic_store_empty, .crc_resync_criteria, .frame_align_resync_criteria,
		.signaling_mf_resync_criteria, .frame_align_search_active,
		.signaling_mf_search_active, .crc_mf_search_active, .crc4_enable,
		.crc_mf_synced, .crc_mf_timeout
	);

	fsi_host_model host
	(
		.core_clk, .host_rdata, .host_port_sel, .host_addr, .host_wr, .host_rd, .host_wdata
	);

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Pin level as settled after the previous edge, free of races at the edge
	always @(negedge core_clk)
		irq_smp <= irq_n;

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_irq(input logic exp);
		chk({7'h00, irq_smp}, {7'h00, exp});
	endtask : chk_irq

	task automatic test_done;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	task automatic t_reset;
		host.rd(2'd0, ADDR_MASK_ONE, v);
		chk(v, 8'h00);
		host.rd(2'd0, 8'h20, v);
		chk(v, 8'h00);
		host.rd(2'd3, ADDR_SUM_LO, v);
		chk(v, 8'h00);
		chk_irq(1'b1);
	endtask : t_reset

	// Loss of sync on port 0: both edges interrupt, read releases
	task automatic t_alarm;
		host.wr(2'd0, ADDR_MASK_ONE, 8'h01);
		ev1[0][0] <= 1'b1;
		tick(3);
		chk_irq(1'b0);
		host.rd(2'd2, 8'h0d, v);
		chk(v, 8'h01);
		host.poll(2'd0, ADDR_STAT_ONE, 8'h01, v);
		chk(v & 8'h01, 8'h01);
		tick(1);
		chk_irq(1'b1);
		ev1[0][0] <= 1'b0;
		tick(3);
		chk_irq(1'b0);
		host.poll(2'd0, ADDR_STAT_ONE, 8'h01, v);
		host.poll(2'd0, ADDR_STAT_ONE, 8'h01, v);
		chk(v & 8'h01, 8'h00);
		chk_irq(1'b1);
	endtask : t_alarm

	task automatic t_mask;
		ev2[3][4] <= 1'b1;
		tick(1);
		ev2[3][4] <= 1'b0;
		tick(3);
		chk_irq(1'b1);
		host.wr(2'd3, ADDR_MASK_TWO, 8'h10);
		tick(2);
		chk_irq(1'b0);
		host.rd(2'd0, ADDR_SUM_HI, v);
		chk(v, 8'h80);
		host.poll(2'd3, ADDR_STAT_TWO, 8'h10, v);
		chk(v & 8'h10, 8'h10);
		tick(1);
		chk_irq(1'b1);
	endtask : t_mask

	task automatic t_events;
		host.wr(2'd1, ADDR_MASK_TWO, 8'h21);
		ev2[1][0] <= 1'b1;
		tick(3);
		chk_irq(1'b0);
		host.rd(2'd0, ADDR_SUM_LO, v);
		chk(v, 8'h08);
		host.poll(2'd1, ADDR_STAT_TWO, 8'h01, v);
		tick(4);
		chk_irq(1'b1);
		ev2[1][0] <= 1'b0;
		tick(1);
		ev2[1][0] <= 1'b1;
		tick(3);
		chk_irq(1'b0);
		ev2[1][0] <= 1'b0;
		ev2[1][5] <= 1'b1;
		host.poll(2'd1, ADDR_STAT_TWO, 8'h21, v);
		tick(2);
		chk_irq(1'b0);
		ev2[1][5] <= 1'b0;
		host.poll(2'd1, ADDR_STAT_TWO, 8'h21, v);
		tick(1);
		chk_irq(1'b1);
	endtask : t_events

	task automatic t_info;
		gain_monitor_in[2] <= 2'b10;
		{jitter_fifo_limit_trip[2], elastic_store_empty[2], crc_resync_criteria[2]} <= 3'h7;
		tick(1);
		{jitter_fifo_limit_trip[2], elastic_store_empty[2], crc_resync_criteria[2]} <= 3'h0;
		host.poll(2'd2, ADDR_RX_INFO, 8'hff, v);
		chk(v, 8'hac);
		{elastic_store_full[2], frame_align_resync_criteria[2]} <= 2'h3;
		signaling_mf_resync_criteria[2] <= 1'b1;
		tick(1);
		{elastic_store_full[2], frame_align_resync_criteria[2]} <= 2'h0;
		signaling_mf_resync_criteria[2] <= 1'b0;
		host.wr(2'd2, ADDR_RX_INFO, 8'h0f);
		host.rd(2'd2, ADDR_RX_INFO, v);
		chk(v, 8'h83);
	endtask : t_info

	task automatic timeouts(input int n);
		repeat (n)
		begin
			crc_mf_timeout[1] <= 1'b1;
			tick(1);
			crc_mf_timeout[1] <= 1'b0;
			tick(1);
		end
	endtask : timeouts

	task automatic t_sync;
		crc4_enable[1] <= 1'b1;
		{frame_align_search_active[1], crc_mf_search_active[1]} <= 2'h3;
		timeouts(7);
		host.wr(2'd1, ADDR_SYNC_STAT, 8'h00);
		host.rd(2'd1, ADDR_SYNC_STAT, v);
		chk(v, 8'h1d);
		crc_mf_synced[1] <= 1'b1;
		tick(1);
		crc_mf_synced[1] <= 1'b0;
		host.rd(2'd1, ADDR_SYNC_STAT, v);
		chk(v, 8'h05);
		timeouts(65);
		host.rd(2'd1, ADDR_SYNC_STAT, v);
		chk(v, 8'h0d);
		crc4_enable[1] <= 1'b0;
		host.rd(2'd1, ADDR_SYNC_STAT, v);
		chk(v, 8'h05);
	endtask : t_sync

	initial
	begin
		{error_cnt, n_compared} = '0;
		{nrst, ev1, ev2, gain_monitor_in, jitter_fifo_limit_trip, elastic_store_full} = '0;
		{elastic_store_empty, crc_resync_criteria, frame_align_resync_criteria} = '0;
		{signaling_mf_resync_criteria, frame_align_search_active} = '0;
		{signaling_mf_search_active, crc_mf_search_active, crc4_enable} = '0;
		{crc_mf_synced, crc_mf_timeout} = '0;
		tick(16);
		nrst <= 1'b1;
		t_reset();
		t_alarm();
		t_mask();
		t_events();
		t_info();
		t_sync();
		test_done();
	end

	initial
	begin
		#(3000 * 100);
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end
endmodule : tb_fsi_top
